/* File: pkg/frt_pkg.sv */
// Package: register map, field positions, reset values and clock codes
package frt_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_CTRL1   = 8'h00;
  localparam logic [7:0] OFS_CTRL2   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_CAP1_HI = 8'h0C;
  localparam logic [7:0] OFS_CAP1_LO = 8'h10;
  localparam logic [7:0] OFS_CAP2_HI = 8'h14;
  localparam logic [7:0] OFS_CAP2_LO = 8'h18;
  localparam logic [7:0] OFS_CNT_HI  = 8'h1C;
  localparam logic [7:0] OFS_CNT_LO  = 8'h20;
  localparam logic [7:0] OFS_ALT_HI  = 8'h24;
  localparam logic [7:0] OFS_ALT_LO  = 8'h28;
  // Field positions of control_reg_one
  localparam int C1_CAP_EDGE1 = 0;
  localparam int C1_CAP_IRQ   = 1;
  localparam int C1_OVF_IRQ   = 2;
  // Field positions of control_reg_two
  localparam int C2_CLK_SEL   = 0;
  localparam int C2_EXT_EDGE  = 2;
  localparam int C2_CAP_EDGE2 = 3;
  localparam int C2_OPM       = 4;
  localparam int C2_PWM       = 5;
  // Field positions of timer_status_reg
  localparam int ST_ICF1      = 0;
  localparam int ST_ICF2      = 1;
  localparam int ST_OVF       = 2;
  // Reset and reload values
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
  localparam logic [1:0]  CLK_SEL_RESET = 2'h0;
  // Clock select codes; internal ratios are a configurable mapping
  localparam logic [1:0]  CS_DIV2 = 2'h0;
  localparam logic [1:0]  CS_DIV4 = 2'h1;
  localparam logic [1:0]  CS_DIV8 = 2'h2;
  localparam logic [1:0]  CS_EXT  = 2'h3;
  // Prescaler terminal counts
  localparam logic [2:0]  PRE_END_DIV2 = 3'h1;
  localparam logic [2:0]  PRE_END_DIV4 = 3'h3;
  localparam logic [2:0]  PRE_END_DIV8 = 3'h7;
  localparam logic [2:0]  PRE_MASK_DIV2 = 3'h1;
  localparam logic [2:0]  PRE_MASK_DIV4 = 3'h3;
  localparam logic [2:0]  PRE_MASK_DIV8 = 3'h7;
  // AHB-Lite codes
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic        HRESP_OKAY = 1'b0;
endpackage

/* File: rtl/frt_edge_sync.sv */
// Two-flop synchroniser with selectable edge detector for one pin
`timescale 1ns/10ps
`default_nettype none
module frt_edge_sync
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  input  wire logic rise_sel,
  output logic      edge_pulse
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
  } frt_sync_t;

  frt_sync_t s;
  frt_sync_t next_s;

  always_comb
  begin
    next_s    = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  // Edge chosen by the select bit, seen only after the second flop
  assign edge_pulse = rise_sel ? (s.s2 & ~s.s3) : (~s.s2 & s.s3);
endmodule // frt_edge_sync
`default_nettype wire

/* File: rtl/frt_timer.sv */
// Free-running 16-bit timer with two input capture channels
`timescale 1ns/10ps
`default_nettype none
module frt_timer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_pin_one,
  input  wire logic        capture_pin_two,
  input  wire logic        cpu_imask,
  input  wire logic        halt_mode,
  output logic             timer_irq
);
  typedef struct packed
  {
    logic [15:0] count;
    logic [2:0]  pre;
    logic        cap_edge1;
    logic        cap_irq_en;
    logic        ovf_irq_en;
    logic [1:0]  clk_sel;
    logic        ext_edge;
    logic        cap_edge2;
    logic        opm;
    logic        pwm;
    logic        ovf;
    logic        icf1;
    logic        icf2;
    logic        ovf_arm;
    logic        icf1_arm;
    logic        icf2_arm;
    logic [7:0]  low_buf;
    logic        latched;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic        inh1;
    logic        inh2;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } frt_state_t;

  frt_state_t s;
  frt_state_t next_s;

  logic ext_pulse;
  logic cap1_pulse;
  logic cap2_pulse;
  logic addr_ph;
  logic rd;
  logic wr;
  logic [7:0] a;
  logic tick;
  logic reload;
  logic trig;
  logic ovf_set;
  logic ovf_clr;
  logic cap1_ev;
  logic cap2_ev;
  logic icf1_clr;
  logic icf2_clr;
  logic cnt_lo_rd;

  function automatic logic is_ofs(input logic [7:0] x, input logic [7:0] o);
    return x == o;
  endfunction

  // External clock pin, synchronised before use
  frt_edge_sync u_ext_sync
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_in     (ext_clock_pin),
    .rise_sel   (s.ext_edge),
    .edge_pulse (ext_pulse)
  );

  // Capture pins are always wired to the channels
  frt_edge_sync u_cap1_sync
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_in     (capture_pin_one),
    .rise_sel   (s.cap_edge1),
    .edge_pulse (cap1_pulse)
  );

  frt_edge_sync u_cap2_sync
  (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_in     (capture_pin_two),
    .rise_sel   (s.cap_edge2),
    .edge_pulse (cap2_pulse)
  );

  always_comb
  begin
    next_s   = s;
    a        = haddr[7:0];
    addr_ph  = hsel & hready & htrans[1] & (hsize == frt_pkg::HSIZE_WORD);
    rd       = addr_ph & ~hwrite;
    wr       = s.wr_pend;
    cnt_lo_rd = rd & (is_ofs(a, frt_pkg::OFS_CNT_LO)
                | is_ofs(a, frt_pkg::OFS_ALT_LO));
    // Prescaler tick or synchronised external edge
    case (s.clk_sel)
      frt_pkg::CS_DIV2:
        tick = (s.pre & frt_pkg::PRE_MASK_DIV2) == frt_pkg::PRE_END_DIV2;
      frt_pkg::CS_DIV4:
        tick = (s.pre & frt_pkg::PRE_MASK_DIV4) == frt_pkg::PRE_END_DIV4;
      frt_pkg::CS_DIV8:
        tick = (s.pre & frt_pkg::PRE_MASK_DIV8) == frt_pkg::PRE_END_DIV8;
      frt_pkg::CS_EXT:
        tick = ext_pulse;
      default:
        tick = 1'b0;
    endcase
    // Halt stops counting, though reload and trigger still load the count; wait mode has no effect
    tick   = tick & ~halt_mode;
    reload = wr & (is_ofs(s.wr_addr, frt_pkg::OFS_CNT_LO)
             | is_ofs(s.wr_addr, frt_pkg::OFS_ALT_LO));
    trig   = (s.opm | s.pwm) & cap1_pulse;
    ovf_set = tick & ~reload & ~trig & (s.count == frt_pkg::COUNT_TOP);
    // Only the primary low byte takes part in the clear
    ovf_clr = s.ovf_arm & ((rd & is_ofs(a, frt_pkg::OFS_CNT_LO))
              | (wr & is_ofs(s.wr_addr, frt_pkg::OFS_CNT_LO)));
    icf1_clr = s.icf1_arm & ((rd & is_ofs(a, frt_pkg::OFS_CAP1_LO))
               | (wr & is_ofs(s.wr_addr, frt_pkg::OFS_CAP1_LO)));
    icf2_clr = s.icf2_arm & ((rd & is_ofs(a, frt_pkg::OFS_CAP2_LO))
               | (wr & is_ofs(s.wr_addr, frt_pkg::OFS_CAP2_LO)));
    // Channel one only captures outside pulse modes
    cap1_ev = cap1_pulse & ~s.opm & ~s.pwm & ~s.inh1;
    cap2_ev = cap2_pulse & ~s.inh2;

    if (!halt_mode)
      next_s.pre = s.pre + 3'h1;
    if (reload || trig)
      next_s.count = frt_pkg::COUNT_RESET;
    else if (tick)
      next_s.count = s.count + 16'h0001;

    // Set wins over clear on every flag
    next_s.ovf  = ovf_set | (s.ovf & ~ovf_clr);
    next_s.icf1 = cap1_ev | (s.icf1 & ~icf1_clr);
    next_s.icf2 = cap2_ev | (s.icf2 & ~icf2_clr);
    if (ovf_clr)
      next_s.ovf_arm = 1'b0;
    if (icf1_clr)
      next_s.icf1_arm = 1'b0;
    if (icf2_clr)
      next_s.icf2_arm = 1'b0;
    if (rd && is_ofs(a, frt_pkg::OFS_STATUS))
    begin
      next_s.ovf_arm  = s.ovf_arm | s.ovf;
      next_s.icf1_arm = s.icf1_arm | s.icf1;
      next_s.icf2_arm = s.icf2_arm | s.icf2;
    end
    // Newest capture overwrites the register
    if (cap1_ev)
      next_s.cap1 = s.count;
    if (cap2_ev)
      next_s.cap2 = s.count;
    // High byte read blocks the channel until its low byte read
    if (rd && is_ofs(a, frt_pkg::OFS_CAP1_HI))
      next_s.inh1 = 1'b1;
    if (rd && is_ofs(a, frt_pkg::OFS_CAP1_LO))
      next_s.inh1 = 1'b0;
    if (rd && is_ofs(a, frt_pkg::OFS_CAP2_HI))
      next_s.inh2 = 1'b1;
    if (rd && is_ofs(a, frt_pkg::OFS_CAP2_LO))
      next_s.inh2 = 1'b0;
    // High byte read of either view freezes a low byte copy
    if (rd && (is_ofs(a, frt_pkg::OFS_CNT_HI)
        || is_ofs(a, frt_pkg::OFS_ALT_HI)))
    begin
      if (!s.latched)
        next_s.low_buf = s.count[7:0];
      next_s.latched = 1'b1;
    end
    else if (cnt_lo_rd)
      next_s.latched = 1'b0;

    // Read data captured at the address phase, shown in the data phase
    next_s.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (a)
        frt_pkg::OFS_CTRL1:
        begin
          next_s.rdata[frt_pkg::C1_CAP_EDGE1] = s.cap_edge1;
          next_s.rdata[frt_pkg::C1_CAP_IRQ]   = s.cap_irq_en;
          next_s.rdata[frt_pkg::C1_OVF_IRQ]   = s.ovf_irq_en;
        end
        frt_pkg::OFS_CTRL2:
        begin
          next_s.rdata[frt_pkg::C2_CLK_SEL +: 2] = s.clk_sel;
          next_s.rdata[frt_pkg::C2_EXT_EDGE]     = s.ext_edge;
          next_s.rdata[frt_pkg::C2_CAP_EDGE2]    = s.cap_edge2;
          next_s.rdata[frt_pkg::C2_OPM]          = s.opm;
          next_s.rdata[frt_pkg::C2_PWM]          = s.pwm;
        end
        frt_pkg::OFS_STATUS:
        begin
          next_s.rdata[frt_pkg::ST_ICF1] = s.icf1;
          next_s.rdata[frt_pkg::ST_ICF2] = s.icf2;
          next_s.rdata[frt_pkg::ST_OVF]  = s.ovf;
        end
        frt_pkg::OFS_CAP1_HI: next_s.rdata[7:0] = s.cap1[15:8];
        frt_pkg::OFS_CAP1_LO: next_s.rdata[7:0] = s.cap1[7:0];
        frt_pkg::OFS_CAP2_HI: next_s.rdata[7:0] = s.cap2[15:8];
        frt_pkg::OFS_CAP2_LO: next_s.rdata[7:0] = s.cap2[7:0];
        frt_pkg::OFS_CNT_HI,
        frt_pkg::OFS_ALT_HI: next_s.rdata[7:0] = s.count[15:8];
        frt_pkg::OFS_CNT_LO,
        frt_pkg::OFS_ALT_LO:
          next_s.rdata[7:0] = s.latched ? s.low_buf : s.count[7:0];
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Write data phase
    if (wr)
    begin
      case (s.wr_addr)
        frt_pkg::OFS_CTRL1:
        begin
          next_s.cap_edge1  = hwdata[frt_pkg::C1_CAP_EDGE1];
          next_s.cap_irq_en = hwdata[frt_pkg::C1_CAP_IRQ];
          next_s.ovf_irq_en = hwdata[frt_pkg::C1_OVF_IRQ];
        end
        frt_pkg::OFS_CTRL2:
        begin
          next_s.clk_sel   = hwdata[frt_pkg::C2_CLK_SEL +: 2];
          next_s.ext_edge  = hwdata[frt_pkg::C2_EXT_EDGE];
          next_s.cap_edge2 = hwdata[frt_pkg::C2_CAP_EDGE2];
          next_s.opm       = hwdata[frt_pkg::C2_OPM];
          next_s.pwm       = hwdata[frt_pkg::C2_PWM];
        end
        default: next_s.wr_pend = 1'b0;
      endcase
    end
    next_s.wr_pend = addr_ph & hwrite;
    next_s.wr_addr = a;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s         <= '0;
      s.count   <= frt_pkg::COUNT_RESET;
      s.clk_sel <= frt_pkg::CLK_SEL_RESET;
    end
    else
      s <= next_s;
  end

  assign hrdata    = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = frt_pkg::HRESP_OKAY;
  // Pending requests raise the line once enabled and unmasked
  assign timer_irq = ~cpu_imask & ((s.ovf & s.ovf_irq_en)
                     | ((s.icf1 | s.icf2) & s.cap_irq_en));

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_armed_low;
    s.ovf_arm ##0 ovf_clr;
  endsequence

  property p_reload;
    reload |=> s.count == frt_pkg::COUNT_RESET;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Counter not reloaded on low write");

  property p_trig_reload;
    trig && !reload |=> s.count == frt_pkg::COUNT_RESET;
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("Pulse trigger did not reload counter");

  property p_alt_keep;
    rd && is_ofs(a, frt_pkg::OFS_ALT_LO) && s.ovf |=> s.ovf;
  endproperty
  a_alt_keep: assert property (p_alt_keep)
    else $error("Alternate low read cleared overflow");

  property p_ovf_set;
    tick && !reload && !trig && s.count == frt_pkg::COUNT_TOP
      |=> s.ovf && s.count == 16'h0000;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("Rollover did not set overflow");

  property p_irq;
    s.ovf && s.ovf_irq_en && !cpu_imask |-> timer_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Overflow interrupt missing");

  property p_ovf_clr;
    s_armed_low and !ovf_set |=> !s.ovf;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("Overflow not cleared by armed low access");

  property p_latch;
    s.latched && !cnt_lo_rd |=> $stable(s.low_buf);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Latched low byte changed");

  property p_live;
    !s.latched && cnt_lo_rd |=> s.rdata[7:0] == $past(s.count[7:0]);
  endproperty
  a_live: assert property (p_live)
    else $error("Lone low read not live");

  property p_halt;
    halt_mode && !reload && !trig |=> $stable(s.count);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Counter moved in halt");

  property p_ext;
    s.clk_sel == frt_pkg::CS_EXT && !halt_mode && !ext_pulse
      && !reload && !trig |=> $stable(s.count);
  endproperty
  a_ext: assert property (p_ext)
    else $error("Counter moved without external edge");

  property p_cap;
    cap2_ev |=> s.cap2 == $past(s.count) && s.icf2;
  endproperty
  a_cap: assert property (p_cap)
    else $error("Capture two did not latch count");

  property p_inh;
    s.inh1 |=> $stable(s.cap1);
  endproperty
  a_inh: assert property (p_inh)
    else $error("Capture one changed while blocked");

  property p_opm;
    (s.opm || s.pwm) && !s.icf1 |=> !s.icf1;
  endproperty
  a_opm: assert property (p_opm)
    else $error("Channel one captured in pulse mode");
endmodule // frt_timer
`default_nettype wire

/* File: testbench/frt_pin_model.sv */
// Pin source model: capture pins and external counter clock
`timescale 1ns/10ps
`default_nettype none
module frt_pin_model
(
  input  wire logic hclk,
  output logic      ext_clock_pin,
  output logic      capture_pin_one,
  output logic      capture_pin_two
);
  initial
  begin
    ext_clock_pin   = 1'b0;
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
  end

  // External clock edges spaced six cycles apart
  task automatic ext_toggle(input int n);
    repeat (n)
    begin
      repeat (6) @(posedge hclk);
      ext_clock_pin <= ~ext_clock_pin;
    end
  endtask

  // Every pin transition reaches the timer; only the edge picked by its select bit gives a pulse
  task automatic cap_toggle(input int ch, input int n);
    repeat (n)
    begin
      repeat (6) @(posedge hclk);
      if (ch == 1)
        capture_pin_one <= ~capture_pin_one;
      else
        capture_pin_two <= ~capture_pin_two;
    end
  endtask
endmodule // frt_pin_model
`default_nettype wire

/* File: testbench/frt_timer_tb.sv */
// Testbench for the free-running timer with input capture
`timescale 1ns/10ps
`default_nettype none
module frt_timer_tb;
  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = frt_pkg::HSIZE_WORD;
  logic [31:0] hwdata    = 32'h0;
  logic        cpu_imask = 1'b0;
  logic        halt_mode = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         timer_irq;
  wire         ext_pin;
  wire         cap_one;
  wire         cap_two;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [31:0] rdv;
  logic [15:0] cnt;
  logic [7:0]  lo_a;

  always #2 hclk = ~hclk;

  frt_timer u_dut
  (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hreadyout),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .ext_clock_pin   (ext_pin),
    .capture_pin_one (cap_one),
    .capture_pin_two (cap_two),
    .cpu_imask       (cpu_imask),
    .halt_mode       (halt_mode),
    .timer_irq       (timer_irq)
  );

  frt_pin_model u_pin
  (
    .hclk            (hclk),
    .ext_clock_pin   (ext_pin),
    .capture_pin_one (cap_one),
    .capture_pin_two (cap_two)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Waits for hready at a rising edge, bounded
  task automatic wait_rdy();
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 50)
      begin
        mismatches++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdv = hrdata;
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic lo_delta(input int n, input logic [7:0] e);
    rd(frt_pkg::OFS_CNT_LO);
    lo_a = rdv[7:0];
    u_pin.ext_toggle(n);
    idle(6);
    rd(frt_pkg::OFS_CNT_LO);
    lo_a = rdv[7:0] - lo_a;
    chk("ext_count", {24'h0, lo_a}, {24'h0, e});
  endtask

  task automatic read_count();
    rd(frt_pkg::OFS_CNT_HI);
    cnt[15:8] = rdv[7:0];
    rd(frt_pkg::OFS_CNT_LO);
    cnt[7:0] = rdv[7:0];
  endtask

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(frt_pkg::OFS_CNT_HI);
    chk("cnt_hi", rdv, 32'hFF);
    chk("hresp", {31'h0, hresp}, {31'h0, frt_pkg::HRESP_OKAY});
    wr(frt_pkg::OFS_CTRL1, 32'h4);
    idle(12);
    rd(frt_pkg::OFS_STATUS);
    chk("ovf", rdv, 32'h4);
    chk("irq", {31'h0, timer_irq}, 32'h1);
    rd(frt_pkg::OFS_ALT_LO);
    rd(frt_pkg::OFS_STATUS);
    chk("ovf_alt", rdv, 32'h4);
    cpu_imask <= 1'b1;
    idle(1);
    chk("irq_mask", {31'h0, timer_irq}, 32'h0);
    rd(frt_pkg::OFS_CNT_LO);
    rd(frt_pkg::OFS_STATUS);
    chk("ovf_clr", rdv, 32'h0);
    cpu_imask <= 1'b0;
    idle(1);
    chk("irq_clr", {31'h0, timer_irq}, 32'h0);
    wr(8'h2C, 32'hFF);
    rd(8'h2C);
    chk("unmapped", rdv, 32'h0);
    $display("test overflow done");

    wr(frt_pkg::OFS_CNT_LO, 32'h0);
    rd(frt_pkg::OFS_CNT_HI);
    chk("reload_hi", rdv, 32'hFF);
    idle(30);
    rd(frt_pkg::OFS_ALT_HI);
    chk("alt_hi", rdv, 32'h0);
    rd(frt_pkg::OFS_CNT_LO);
    chk("frozen_lo", rdv & 32'hFFFFFFFC, 32'hFC);
    $display("test latch done");

    // Codes 0..2 are divide by 2, 4, 8
    for (int i = 0; i < 3; i++)
    begin
      wr(frt_pkg::OFS_CTRL2, 32'(i));
      rd(frt_pkg::OFS_CNT_LO);
      lo_a = rdv[7:0];
      idle(78);
      rd(frt_pkg::OFS_CNT_LO);
      lo_a = rdv[7:0] - lo_a;
      chk("rate", {24'h0, lo_a}, 32'(80 >> (i + 1)));
    end
    $display("test prescaler done");

    wr(frt_pkg::OFS_CTRL2, 32'h7);
    lo_delta(6, 8'h3);
    wr(frt_pkg::OFS_CTRL2, 32'h3);
    lo_delta(3, 8'h1);
    $display("test external clock done");

    wr(frt_pkg::OFS_CTRL2, 32'h0);
    halt_mode <= 1'b1;
    idle(2);
    read_count();
    idle(20);
    rd(frt_pkg::OFS_CNT_LO);
    chk("halt_lo", rdv, {24'h0, cnt[7:0]});
    wr(frt_pkg::OFS_CTRL1, 32'h3);
    u_pin.cap_toggle(1, 1);
    idle(6);
    chk("cap_irq", {31'h0, timer_irq}, 32'h1);
    rd(frt_pkg::OFS_STATUS);
    chk("icf1", rdv & 32'h3, 32'h1);
    cpu_imask <= 1'b1;
    idle(1);
    chk("cap_mask", {31'h0, timer_irq}, 32'h0);
    cpu_imask <= 1'b0;
    idle(1);
    chk("cap_pend", {31'h0, timer_irq}, 32'h1);
    rd(frt_pkg::OFS_CAP1_HI);
    chk("cap1_hi", rdv, {24'h0, cnt[15:8]});
    rd(frt_pkg::OFS_CAP1_LO);
    chk("cap1_lo", rdv, {24'h0, cnt[7:0]});
    rd(frt_pkg::OFS_STATUS);
    chk("icf1_clr", rdv & 32'h3, 32'h0);
    chk("irq_off", {31'h0, timer_irq}, 32'h0);
    rd(frt_pkg::OFS_CAP2_HI);
    u_pin.cap_toggle(2, 2);
    idle(6);
    rd(frt_pkg::OFS_STATUS);
    chk("icf2_block", rdv & 32'h3, 32'h0);
    rd(frt_pkg::OFS_CAP2_LO);
    rd(frt_pkg::OFS_STATUS);
    chk("icf2_after", rdv & 32'h3, 32'h0);
    u_pin.cap_toggle(2, 2);
    halt_mode <= 1'b0;
    idle(40);
    halt_mode <= 1'b1;
    idle(2);
    read_count();
    u_pin.cap_toggle(2, 2);
    idle(6);
    rd(frt_pkg::OFS_STATUS);
    chk("icf2", rdv & 32'h3, 32'h2);
    rd(frt_pkg::OFS_CAP2_HI);
    chk("cap2_hi", rdv, {24'h0, cnt[15:8]});
    rd(frt_pkg::OFS_CAP2_LO);
    chk("cap2_lo", rdv, {24'h0, cnt[7:0]});
    wr(frt_pkg::OFS_CTRL2, 32'h10);
    u_pin.cap_toggle(1, 2);
    u_pin.cap_toggle(2, 2);
    idle(6);
    rd(frt_pkg::OFS_STATUS);
    chk("pulse_mode", rdv & 32'h3, 32'h2);
    read_count();
    chk("opm_reload", {16'h0, cnt}, {16'h0, frt_pkg::COUNT_RESET});
    halt_mode <= 1'b0;
    idle(4);
    halt_mode <= 1'b1;
    wr(frt_pkg::OFS_CTRL2, 32'h28);
    u_pin.cap_toggle(1, 2);
    u_pin.cap_toggle(2, 1);
    idle(6);
    read_count();
    chk("pwm_reload", {16'h0, cnt}, {16'h0, frt_pkg::COUNT_RESET});
    rd(frt_pkg::OFS_STATUS);
    chk("pwm_icf1", rdv & 32'h1, 32'h0);
    rd(frt_pkg::OFS_CAP2_HI);
    chk("cap2_rise_hi", rdv, 32'hFF);
    rd(frt_pkg::OFS_CAP2_LO);
    chk("cap2_rise_lo", rdv, 32'hFC);
    $display("test capture done");
    hresetn <= 1'b0;
    idle(3);
    hresetn <= 1'b1;
    read_count();
    chk("reset_wake", {16'h0, cnt}, {16'h0, frt_pkg::COUNT_RESET});
    halt_mode <= 1'b0;
    $display("test reset done");
    complete_run();
  end
endmodule // frt_timer_tb
`default_nettype wire
